//--- efb_embedded_flash_bank_ctrl.sv
// flash bank controller: ecc reads, background row_line program and sector erase
// How it works
// - one byte per read, three cpu clocks
// - program unit is one 32-byte row_line
// - erase whole sectors, one or several together
// - erased cells read as zero
// - program bank row_line programmed once only
// - data bank row_line programmable twice
// - correct single-bit errors before delivery
// - program and erase run in background
// - erase may be aborted while running
// - program lasts 209440 system clocks
// - erase lasts 8175360 system clocks
// - four 4-Kbyte banks, one data bank
// - fixed sector layouts per bank type
`timescale 1ns/1ps
module efb_embedded_flash_bank_ctrl #(
  parameter int unsigned PROG_CYCLES  = efb_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYCLES = efb_pkg::ERASE_CYC
) (
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  // read port
  input  wire logic                       rd_req_in,
  input  wire logic [efb_pkg::ADDR_W-1:0] rd_addr_in,
  output logic                            rd_valid_out,
  output logic [7:0]                      rd_data_out,
  output logic                            rd_corrected_out,
  // program and erase request port
  input  efb_pkg::efb_op_s                op_in,
  input  wire logic                       abort_in,
  output logic                            op_accept_out,
  output logic                            op_reject_out,
  output logic                            busy_out,
  output logic                            done_out
);
  localparam int unsigned MEM_W   = 8 + efb_pkg::ECC_W;
  localparam int unsigned MEM_N   = efb_pkg::NUM_BANKS * efb_pkg::BANK_BYTES;
  localparam int unsigned NROWS   = efb_pkg::NUM_BANKS * efb_pkg::ROWS_PER_BANK;
  localparam logic [efb_pkg::CNT_W-1:0] PROG_LAST  = efb_pkg::CNT_W'(PROG_CYCLES - 1);
  localparam logic [efb_pkg::CNT_W-1:0] ERASE_LAST = efb_pkg::CNT_W'(ERASE_CYCLES - 1);
  // five bits: the read count runs past fifteen at this clock rate
  localparam logic [4:0] RD_LAST = 5'(efb_pkg::READ_CYC - 1);

  // hamming(12,8) check bits; all-zero byte gives all-zero code so erased cells stay clean
  function automatic logic [3:0] ecc_gen(input logic [7:0] d);
    ecc_gen[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    ecc_gen[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    ecc_gen[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    ecc_gen[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
  endfunction

  // sector index of a bank offset; data bank is finer grained
  function automatic logic [3:0] sect_of(input logic is_data, input logic [11:0] o);
    if (!is_data) begin
      sect_of = (o < 12'hf00) ? 4'h0 : ((o < 12'hf80) ? 4'h1 : 4'h2);
    end else if (o < 12'h800) begin
      sect_of = {3'h0, o[10]};
    end else if (o < 12'hc00) begin
      sect_of = 4'h2 + {3'h0, o[9]};
    end else if (o < 12'he00) begin
      sect_of = 4'h4 + {3'h0, o[8]};
    end else begin
      sect_of = 4'h6 + {2'h0, o[8:7]};
    end
  endfunction

  logic [MEM_W-1:0]             mem [MEM_N];
  logic [1:0]                   prog_cnt [NROWS];
  efb_pkg::efb_state_e          state;
  logic [efb_pkg::CNT_W-1:0]    tmr;
  efb_pkg::efb_op_s             cur;
  logic [4:0]                   rd_tmr;
  logic                         rd_busy;
  logic [efb_pkg::ADDR_W-1:0]   rd_addr;
  logic                         wipe;

  // decode of the incoming request
  wire [1:0]  req_bank    = op_in.addr[13:12];
  wire        req_is_data = (req_bank == 2'(efb_pkg::DATA_BANK));
  localparam int unsigned ROW_W_C = efb_pkg::ROW_W;
  wire [ROW_W_C-1:0] req_row = op_in.addr[13:5];
  wire [1:0]  req_limit   = req_is_data ? efb_pkg::PRG_LIMIT_DATA : efb_pkg::PRG_LIMIT_PROG;
  wire        row_full    = (prog_cnt[req_row] >= req_limit);
  wire        idle        = (state == efb_pkg::ST_IDLE);
  wire        take_op     = op_in.valid && idle && !(!op_in.is_erase && row_full)
                            && !(op_in.is_erase && op_in.sect_mask == '0);
  wire        refuse_op   = op_in.valid && !take_op;
  wire        tmr_end     = (state == efb_pkg::ST_PROG) ? (tmr == PROG_LAST)
                                                        : (tmr == ERASE_LAST);
  wire        finish      = !idle && tmr_end;
  wire        abort_now   = (state == efb_pkg::ST_ERASE) && abort_in;
  wire [1:0]  cur_bank    = cur.addr[13:12];
  wire        cur_is_data = (cur_bank == 2'(efb_pkg::DATA_BANK));

  // read path with single-bit correction
  wire [MEM_W-1:0] rd_word = mem[rd_addr];
  wire [7:0]  rd_raw   = rd_word[7:0];
  wire [3:0]  rd_syn   = ecc_gen(rd_raw) ^ rd_word[11:8];
  // syndrome position map: data bits live at codeword positions 3,5,6,7,9,10,11,12
  wire [7:0]  rd_flip;
  genvar gi;
  localparam logic [31:0] POS = 32'hcba97653;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flip
      assign rd_flip[gi] = (rd_syn == POS[gi*4 +: 4]);
    end
  endgenerate
  wire [7:0]  rd_fixed = rd_raw ^ rd_flip;

  // sequencer: program and erase run while reads continue
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= efb_pkg::ST_IDLE;
      tmr   <= '0;
      cur   <= '0;
    end else if (take_op) begin
      state <= op_in.is_erase ? efb_pkg::ST_ERASE : efb_pkg::ST_PROG;
      tmr   <= '0;
      cur   <= op_in;
    end else if (finish || abort_now) begin
      state <= efb_pkg::ST_IDLE;
      tmr   <= '0;
    end else if (!idle) begin
      tmr <= tmr + efb_pkg::CNT_W'(1);
    end
  end

  // handshake and status outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      op_accept_out <= 1'b0;
      op_reject_out <= 1'b0;
      busy_out      <= 1'b0;
      done_out      <= 1'b0;
    end else begin
      op_accept_out <= take_op;
      op_reject_out <= refuse_op;
      busy_out      <= take_op || (!idle && !finish && !abort_now);
      done_out      <= finish || abort_now;
    end
  end

  // array update at the end of an operation; a wipe after reset models erased delivery
  always_ff @(posedge clk_sys_in) begin
    if (wipe) begin
      for (int i = 0; i < MEM_N; i++) begin
        mem[i] <= '0;
      end
      for (int r = 0; r < NROWS; r++) begin
        prog_cnt[r] <= 2'h0;
      end
    end else if (finish && state == efb_pkg::ST_PROG) begin
      for (int b = 0; b < efb_pkg::ROW_BYTES; b++) begin
        mem[{cur.addr[13:5], 5'(b)}] <= {ecc_gen(cur.data[b*8 +: 8]) | mem[{cur.addr[13:5], 5'(b)}][11:8],
                                         cur.data[b*8 +: 8] | mem[{cur.addr[13:5], 5'(b)}][7:0]};
      end
      prog_cnt[cur.addr[13:5]] <= prog_cnt[cur.addr[13:5]] + 2'h1;
    end else if (finish && state == efb_pkg::ST_ERASE) begin
      for (int a = 0; a < efb_pkg::BANK_BYTES; a++) begin
        if (cur.sect_mask[sect_of(cur_is_data, 12'(a))]) begin
          mem[{cur_bank, 12'(a)}] <= '0;
        end
      end
      for (int r = 0; r < efb_pkg::ROWS_PER_BANK; r++) begin
        if (cur.sect_mask[sect_of(cur_is_data, 12'(r * efb_pkg::ROW_BYTES))]) begin
          prog_cnt[{cur_bank, 7'(r)}] <= 2'h0;
        end
      end
    end
  end

  // one-shot wipe flag right after reset release
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wipe <= 1'b1;
    end else begin
      wipe <= 1'b0;
    end
  end

  // read timing: address held, data out after three cpu clocks
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_busy          <= 1'b0;
      rd_tmr           <= '0;
      rd_addr          <= '0;
      rd_valid_out     <= 1'b0;
      rd_data_out      <= '0;
      rd_corrected_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      if (!rd_busy && rd_req_in) begin
        rd_busy <= 1'b1;
        rd_tmr  <= '0;
        rd_addr <= rd_addr_in;
      end else if (rd_busy && rd_tmr == RD_LAST) begin
        rd_busy          <= 1'b0;
        rd_valid_out     <= 1'b1;
        rd_data_out      <= rd_fixed;
        rd_corrected_out <= (rd_syn != 4'h0);
      end else if (rd_busy) begin
        rd_tmr <= rd_tmr + 5'h1;
      end
    end
  end

  // zeros on reprogram: programmed bits are or-ed in, so zeros keep them
endmodule

//--- efb_pkg.sv
// shared constants and carrier types for the embedded flash bank controller
package efb_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned SYS_MHZ        = 80;
  localparam int unsigned CCLK_DIV       = 3;
  localparam int unsigned READ_CCLK      = 3;
  localparam int unsigned READ_CYC       = READ_CCLK * CCLK_DIV * CLK_MHZ / SYS_MHZ;
  localparam int unsigned PROG_SYS       = 209440;
  localparam int unsigned ERASE_SYS      = 8175360;
  localparam int unsigned PROG_CYC       = PROG_SYS * CLK_MHZ / SYS_MHZ;
  localparam int unsigned ERASE_CYC      = ERASE_SYS * CLK_MHZ / SYS_MHZ;
  localparam int unsigned NUM_BANKS      = 4;
  localparam int unsigned DATA_BANK      = 0;
  localparam int unsigned BANK_BYTES     = 4096;
  localparam int unsigned ROW_BYTES      = 32;
  localparam int unsigned ROWS_PER_BANK  = BANK_BYTES / ROW_BYTES;
  localparam int unsigned ADDR_W         = 14;
  localparam int unsigned ROW_W          = 9;
  localparam int unsigned CNT_W          = 26;
  localparam int unsigned NUM_SECT       = 10;
  localparam int unsigned ECC_W          = 4;
  localparam logic [1:0]  PRG_LIMIT_PROG = 2'h1;
  localparam logic [1:0]  PRG_LIMIT_DATA = 2'h2;
  localparam logic [ADDR_W-1:0] BANK_OFS = 14'h1000;

  typedef struct packed {
    logic                    valid;
    logic                    is_erase;
    logic [ADDR_W-1:0]       addr;
    logic [NUM_SECT-1:0]     sect_mask;
    logic [ROW_BYTES*8-1:0]  data;
  } efb_op_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b100
  } efb_state_e;
endpackage

//--- efb_chk_asserts.sv
// port checker for the flash bank controller
`timescale 1ns/1ps
module efb_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  // watched ports
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       rd_req_in,
  input wire logic       rd_valid_out,
  input wire logic [7:0] rd_data_out,
  input wire logic       rd_corrected_out,
  input efb_pkg::efb_op_s op_in,
  input wire logic       abort_in,
  input wire logic       op_accept_out,
  input wire logic       op_reject_out,
  input wire logic       busy_out,
  input wire logic       done_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // request is sampled one edge before the read count starts
  localparam int RD_DEPTH = efb_pkg::READ_CYC + 1;
  logic er;
  // erase in flight; abort must not be judged while a program runs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      er <= 1'b0;
    else
      er <= op_accept_out ? $past(op_in.is_erase) : (er && !done_out);
  end
  property p_rd_lat; rd_valid_out |-> $past(rd_req_in, RD_DEPTH); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
  property p_rd_pulse; rd_valid_out |=> !rd_valid_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid too long");
  property p_rd_hold; !rd_valid_out |-> $stable({rd_data_out, rd_corrected_out}); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rej_busy; busy_out && !done_out && op_in.valid |=> op_reject_out && !op_accept_out;
  endproperty
  a_rej_busy: assert property (p_rej_busy) else $error("request taken while busy");
  property p_prog_time;
    op_accept_out && !$past(op_in.is_erase) |-> ##PROG_CYCLES done_out;
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program time wrong");
  property p_bg_quiet; op_accept_out |=> (busy_out && !done_out) [*8]; endproperty
  a_bg_quiet: assert property (p_bg_quiet) else $error("operation ended early");
  property p_abort; er && abort_in |=> done_out; endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");
  property p_done; done_out |=> !done_out && !busy_out; endproperty
  a_done: assert property (p_done) else $error("busy after done");
  c_prog: cover property (op_accept_out && !$past(op_in.is_erase));
  c_abort: cover property (er && abort_in);
  c_read: cover property (rd_valid_out);
  c_corr: cover property (rd_valid_out && rd_corrected_out);
endmodule
bind efb_embedded_flash_bank_ctrl efb_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

//--- efb_cpu_model.sv
// cpu side read model: one-cycle request, then waits for the byte
`timescale 1ns/1ps
module efb_cpu_model (
  // clock and answer
  input wire logic                        clk_sys_in,
  input wire logic                        rd_valid_out,
  input wire logic [7:0]                  rd_data_out,
  // request
  output logic                            rd_req_in,
  output logic [efb_pkg::ADDR_W-1:0]      rd_addr_in
);
  initial begin
    rd_req_in = 1'b0;
    rd_addr_in = '0;
  end
  // address is inverted once taken so a stale value cannot pass
  task automatic rd(input logic [13:0] a, output logic [7:0] d, output int n);
    @(negedge clk_sys_in);
    rd_req_in = 1'b1;
    rd_addr_in = a;
    @(negedge clk_sys_in);
    rd_req_in = 1'b0;
    rd_addr_in = ~a;
    n = 0;
    while (rd_valid_out !== 1'b1 && n < 40) begin
      @(negedge clk_sys_in);
      n++;
    end
    d = rd_data_out;
  endtask
endmodule

//--- efb_embedded_flash_bank_ctrl_test.sv
// testbench for the flash bank controller
`timescale 1ns/1ps
module efb_embedded_flash_bank_ctrl_test;
  localparam int PC = 20;
  localparam int EC = 40;
  logic clk_sys_in, rst_in, abort_in, rd_req_in, rd_valid_out, rd_corrected_out;
  logic op_accept_out, op_reject_out, busy_out, done_out;
  logic [13:0] rd_addr_in;
  logic [7:0] rd_data_out;
  efb_pkg::efb_op_s op_in;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [255:0] d1 = {128'h0, {16{8'ha5}}};
  logic [255:0] d2 = {{16{8'h3c}}, 128'h0};
  efb_embedded_flash_bank_ctrl #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) u_dut (.*);
  efb_cpu_model u_cpu (.*);
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // read one byte, check value and latency
  task automatic rdc(input logic [13:0] a, input logic [7:0] e, input logic c);
    logic [7:0] d;
    int n;
    u_cpu.rd(a, d, n);
    // a read that never answers ends the run
    if (n >= 40) begin
      n_mismatch++;
      finish_test();
    end
    chk("rd_cycles", efb_pkg::READ_CYC, n);
    chk("rd_data", e, d);
    chk("rd_corrected", c, rd_corrected_out);
  endtask
  // one program or erase; b retries while busy, ab aborts mid-erase
  task automatic op(input logic e, input logic [13:0] a, input logic [9:0] m,
                    input logic [255:0] d, input logic ok, input int cyc,
                    input logic b, input logic ab);
    int n;
    @(negedge clk_sys_in);
    op_in = '{1'b1, e, a, m, d};
    @(negedge clk_sys_in);
    op_in.valid = 1'b0;
    // answer pulses stand for one cycle only: look at them right away
    chk("accept", ok, op_accept_out);
    chk("reject", !ok, op_reject_out);
    chk("busy", ok, busy_out);
    n = 1;
    if (b) begin
      @(negedge clk_sys_in);
      op_in.valid = 1'b1;
      @(negedge clk_sys_in);
      op_in.valid = 1'b0;
      chk("busy_reject", 1, op_reject_out);
      n += 2;
    end
    if (ab) begin
      repeat (8) @(negedge clk_sys_in);
      abort_in = 1'b1;
      @(negedge clk_sys_in);
      abort_in = 1'b0;
      n += 9;
    end
    while (ok && done_out !== 1'b1 && n < 60) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 60) begin
      n_mismatch++;
      finish_test();
    end
    if (ok) begin
      chk("op_cycles", cyc, n);
      chk("busy_end", 0, busy_out);
    end
  endtask
  initial begin
    rst_in = 1'b1;
    abort_in = 1'b0;
    op_in = '0;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk("rst_busy", 0, busy_out);
    chk("rst_done", 0, done_out);
    for (int b = 0; b < 4; b++)
      rdc(14'(b * 4096 + 4095), 8'h00, 1'b0);
    op(0, 14'h0000, 10'h000, d1, 1, PC + 1, 1, 0);
    op(0, 14'h0400, 10'h000, d1, 1, PC + 1, 0, 0);
    op(0, 14'h0000, 10'h000, d2, 1, PC + 1, 0, 0);
    op(0, 14'h0000, 10'h000, d2, 0, 0, 0, 0);
    rdc(14'h0003, 8'ha5, 1'b0);
    rdc(14'h0014, 8'h3c, 1'b0);
    op(0, 14'h1000, 10'h000, d1, 1, PC + 1, 0, 0);
    op(0, 14'h1000, 10'h000, d2, 0, 0, 0, 0);
    op(1, 14'h0000, 10'h000, d1, 0, 0, 0, 0);
    // abort raised eight cycles after accept, done one cycle later
    op(1, 14'h0000, 10'h001, d1, 1, 10, 0, 1);
    rdc(14'h0003, 8'ha5, 1'b0);
    op(1, 14'h0000, 10'h001, d1, 1, EC + 1, 0, 0);
    rdc(14'h0003, 8'h00, 1'b0);
    rdc(14'h0400, 8'ha5, 1'b0);
    op(1, 14'h1000, 10'h007, d1, 1, EC + 1, 0, 0);
    op(0, 14'h1000, 10'h000, d1, 1, PC + 1, 0, 0);
    rdc(14'h1000, 8'ha5, 1'b0);
    // second program breaks the zero rule on purpose: one flipped data bit
    op(0, 14'h0020, 10'h000, 256'h08, 1, PC + 1, 0, 0);
    op(0, 14'h0020, 10'h000, 256'h01, 1, PC + 1, 0, 0);
    rdc(14'h0020, 8'h08, 1'b1);
    finish_test();
  end
endmodule
